//--- common/sfcra_cfg.svh
// Purpose: constants for the serial flash command front end
// Assumes: single-line transfers only; mode 0 sampling
// Notes: opcodes, phase counts and array limits
`ifndef SFCRA_CFG_SVH
`define SFCRA_CFG_SVH
`define SFCRA_OP_READ 8'h03
`define SFCRA_OP_FREAD 8'h0B
`define SFCRA_OP_RDSR1 8'h05
`define SFCRA_OP_RDSR2 8'h35
`define SFCRA_OP_RDSR3 8'h15
`define SFCRA_OP_WRSR1 8'h01
`define SFCRA_OP_WRSR2 8'h31
`define SFCRA_OP_WRSR3 8'h11
`define SFCRA_OP_SFDP 8'h5A
`define SFCRA_OP_UID 8'h4B
`define SFCRA_OP_PP 8'h02
`define SFCRA_OP_QPP 8'h32
`define SFCRA_OP_BE4 8'h20
`define SFCRA_OP_BE32 8'h52
`define SFCRA_OP_BE64 8'hD8
`define SFCRA_OP_CE1 8'hC7
`define SFCRA_OP_CE2 8'h60
`define SFCRA_OP_SUSP 8'h75
`define SFCRA_OP_RESM 8'h7A
`define SFCRA_OP_SECER 8'h44
`define SFCRA_OP_SECPG 8'h42
`define SFCRA_OP_SECRD 8'h48
`define SFCRA_OP_MID 8'h90
`define SFCRA_OP_MID2 8'h92
`define SFCRA_OP_MID4 8'h94
`define SFCRA_OP_JID 8'h9F
`define SFCRA_OP_BITS 6'h08
`define SFCRA_ADDR_BITS 6'h18
`define SFCRA_DUMMY_BYTE 6'h08
`define SFCRA_DUMMY_UID 6'h20
`define SFCRA_ADDR_TOP 19'h7FFFF
`define SFCRA_ADDR_W 19
`endif

//--- common/sfcra_pkg.sv
// Purpose: shared types of the serial flash command front end
// Assumes: nothing beyond the config header
// Notes: phase state and command class
package sfcra_pkg;
  typedef enum logic [5:0] {
    SFCRA_IDLE = 6'h01,
    SFCRA_OPC = 6'h02,
    SFCRA_ADR = 6'h04,
    SFCRA_DUM = 6'h08,
    SFCRA_DAT = 6'h10,
    SFCRA_IGN = 6'h20
  } sfcra_phase_e;
  typedef enum logic [3:0] {
    SFCRA_C_NONE = 4'h0,
    SFCRA_C_ARRAY = 4'h1,
    SFCRA_C_RDSR = 4'h2,
    SFCRA_C_WRSR = 4'h3,
    SFCRA_C_SFDP = 4'h4,
    SFCRA_C_UID = 4'h5,
    SFCRA_C_ADRONLY = 4'h6,
    SFCRA_C_OPONLY = 4'h7,
    SFCRA_C_ADRDATA = 4'h8,
    SFCRA_C_JID = 4'h9
  } sfcra_cls_e;
endpackage

//--- hw/sfcra_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to core_clk_i
// Notes: first stage is read only by the second
`timescale 1ns/10ps
module sfcra_sync (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] pin_i,
  output logic [2:0] sync_o
);
  logic [2:0] meta;
  // Pins settle here before any logic sees them
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= 3'h4; // Idle pins: deselected, clock low
      sync_o <= 3'h4; // Matches edge finder reset, no false edge
    end else begin
      meta <= pin_i;
      sync_o <= meta;
    end
  end
endmodule

//--- hw/sfcra_front.sv
// Purpose: single-line SPI command front end of a serial flash
// Assumes: SPI mode 0; serial clock oversampled by core_clk_i
// Notes: array and status storage sit outside; reads via array port
`timescale 1ns/10ps
`include "sfcra_cfg.svh"
module sfcra_front
  import sfcra_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  output logic [`SFCRA_ADDR_W-1:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  input wire logic [7:0] stat1_i,
  input wire logic [7:0] stat2_i,
  input wire logic [7:0] stat3_i,
  input wire logic [7:0] id_data_i,
  output logic [1:0] st_wr_sel_o,
  output logic [7:0] st_wr_data_o,
  output logic st_wr_o,
  output logic [7:0] cmd_op_o,
  output logic [23:0] cmd_addr_o,
  output logic cmd_o,
  output logic [7:0] wr_data_o,
  output logic wr_o
);
  logic [2:0] pins;
  logic cs_n;
  logic sck;
  logic si;
  logic sck_d;
  logic rise;
  logic fall;
  sfcra_phase_e phase;
  sfcra_cls_e cls;
  logic [5:0] cnt;
  logic [7:0] op;
  logic [23:0] adr;
  logic [7:0] shin;
  logic [7:0] shout;
  logic [2:0] bitn;
  logic got_data;
  // Classify an opcode; used on the final opcode bit
  function automatic sfcra_cls_e op_class(input logic [7:0] o);
    case (o)
      `SFCRA_OP_READ, `SFCRA_OP_FREAD: op_class = SFCRA_C_ARRAY;
      `SFCRA_OP_RDSR1, `SFCRA_OP_RDSR2,
      `SFCRA_OP_RDSR3: op_class = SFCRA_C_RDSR;
      `SFCRA_OP_WRSR1, `SFCRA_OP_WRSR2,
      `SFCRA_OP_WRSR3: op_class = SFCRA_C_WRSR;
      `SFCRA_OP_SFDP, `SFCRA_OP_SECRD: op_class = SFCRA_C_SFDP;
      `SFCRA_OP_UID: op_class = SFCRA_C_UID;
      `SFCRA_OP_BE4, `SFCRA_OP_BE32, `SFCRA_OP_BE64,
      `SFCRA_OP_SECER: op_class = SFCRA_C_ADRONLY;
      `SFCRA_OP_CE1, `SFCRA_OP_CE2, `SFCRA_OP_SUSP,
      `SFCRA_OP_RESM: op_class = SFCRA_C_OPONLY;
      `SFCRA_OP_PP, `SFCRA_OP_QPP, `SFCRA_OP_SECPG,
      `SFCRA_OP_MID, `SFCRA_OP_MID2,
      `SFCRA_OP_MID4: op_class = SFCRA_C_ADRDATA;
      `SFCRA_OP_JID: op_class = SFCRA_C_JID;
      default: op_class = SFCRA_C_NONE;
    endcase
  endfunction

  // Select the status byte an opcode names
  function automatic logic [1:0] sr_sel(input logic [7:0] o);
    case (o)
      `SFCRA_OP_RDSR2, `SFCRA_OP_WRSR2: sr_sel = 2'h1;
      `SFCRA_OP_RDSR3, `SFCRA_OP_WRSR3: sr_sel = 2'h2;
      default: sr_sel = 2'h0;
    endcase
  endfunction
  sfcra_sync u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pin_i({cs_n_i, sck_i, si_i}),
    .sync_o(pins)
  );
  assign cs_n = pins[2];
  assign sck = pins[1];
  assign si = pins[0];
  assign rise = sck & ~sck_d & ~cs_n;
  assign fall = ~sck & sck_d & ~cs_n;
  // Edge finder on the synchronised serial clock
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck;
    end
  end
  logic [7:0] shin_n;
  assign shin_n = {shin[6:0], si};
  // Phase sequencer; deselect always returns to idle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= SFCRA_IDLE;
      cls <= SFCRA_C_NONE;
      cnt <= 6'h00;
      op <= 8'h00;
      adr <= 24'h000000;
      shin <= 8'h00;
    end else if (cs_n) begin
      phase <= SFCRA_IDLE;
      cnt <= 6'h00;
    end else if (phase == SFCRA_IDLE) begin
      phase <= SFCRA_OPC;
      cnt <= 6'h00;
    end else if (rise) begin
      shin <= shin_n;
      unique case (phase)
        SFCRA_OPC: begin
          cnt <= cnt + 6'h01;
          if (cnt == `SFCRA_OP_BITS - 6'h01) begin
            op <= shin_n;
            cls <= op_class(shin_n);
            cnt <= 6'h00;
            unique case (op_class(shin_n))
              SFCRA_C_NONE: phase <= SFCRA_IGN;
              SFCRA_C_OPONLY: phase <= SFCRA_IGN;
              SFCRA_C_RDSR, SFCRA_C_WRSR,
              SFCRA_C_JID: phase <= SFCRA_DAT;
              SFCRA_C_UID: phase <= SFCRA_DUM;
              default: phase <= SFCRA_ADR;
            endcase
          end
        end
        SFCRA_ADR: begin
          adr <= {adr[22:0], si};
          cnt <= cnt + 6'h01;
          if (cnt == `SFCRA_ADDR_BITS - 6'h01) begin
            cnt <= 6'h00;
            if (cls == SFCRA_C_ADRONLY)
              phase <= SFCRA_IGN;
            else if (cls == SFCRA_C_SFDP ||
                     op == `SFCRA_OP_FREAD)
              phase <= SFCRA_DUM;
            else
              phase <= SFCRA_DAT;
          end
        end
        SFCRA_DUM: begin
          cnt <= cnt + 6'h01;
          if ((cls == SFCRA_C_UID && cnt == `SFCRA_DUMMY_UID - 6'h01)
              || (cls != SFCRA_C_UID &&
                  cnt == `SFCRA_DUMMY_BYTE - 6'h01)) begin
            cnt <= 6'h00;
            phase <= SFCRA_DAT;
          end
        end
        SFCRA_DAT, SFCRA_IGN: cnt <= 6'h00;
        default: phase <= SFCRA_IGN;
      endcase
    end
  end
  // Input data bytes: count bits, report each full byte of address-data commands; status writes report only the first
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bitn <= 3'h0;
      got_data <= 1'b0;
      st_wr_o <= 1'b0;
      st_wr_sel_o <= 2'h0;
      st_wr_data_o <= 8'h00;
      wr_o <= 1'b0;
      wr_data_o <= 8'h00;
    end else begin
      st_wr_o <= 1'b0;
      wr_o <= 1'b0;
      if (phase != SFCRA_DAT) begin
        bitn <= 3'h0;
        got_data <= 1'b0;
      end else if (rise) begin
        bitn <= bitn + 3'h1;
        if (bitn == 3'h7) begin
          got_data <= 1'b1;
          if (cls == SFCRA_C_WRSR && !got_data) begin
            st_wr_o <= 1'b1;
            st_wr_sel_o <= sr_sel(op);
            st_wr_data_o <= shin_n;
          end
          if (cls == SFCRA_C_ADRDATA) begin
            wr_o <= 1'b1;
            wr_data_o <= shin_n;
          end
        end
      end
    end
  end
  // Command report at deselect once opcode and address are complete
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_o <= 1'b0;
      cmd_op_o <= 8'h00;
      cmd_addr_o <= 24'h000000;
    end else begin
      cmd_o <= 1'b0;
      if (cs_n && phase != SFCRA_IDLE && phase != SFCRA_OPC &&
          phase != SFCRA_ADR && cls != SFCRA_C_NONE) begin
        cmd_o <= 1'b1;
        cmd_op_o <= op;
        cmd_addr_o <= adr;
      end
    end
  end
  logic rd_cls;
  assign rd_cls = (cls == SFCRA_C_ARRAY || cls == SFCRA_C_SFDP ||
                   cls == SFCRA_C_UID || cls == SFCRA_C_RDSR ||
                   cls == SFCRA_C_JID ||
                   op == `SFCRA_OP_MID || op == `SFCRA_OP_MID2 ||
                   op == `SFCRA_OP_MID4);
  // Output shifter; address counter advances per byte
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shout <= 8'h00;
      rd_addr_o <= '0;
      so_oe_o <= 1'b0;
    end else if (cs_n) begin
      so_oe_o <= 1'b0;
    end else if (phase != SFCRA_DAT || !rd_cls) begin
      if (phase == SFCRA_ADR && rise) // Last bit lands this cycle
        rd_addr_o <= {adr[`SFCRA_ADDR_W-2:0], si};
      else
        rd_addr_o <= adr[`SFCRA_ADDR_W-1:0];
      so_oe_o <= 1'b0;
    end else if (fall) begin
      so_oe_o <= 1'b1;
      if (bitn == 3'h0) begin
        unique case (cls)
          SFCRA_C_RDSR: shout <= (sr_sel(op) == 2'h1) ? stat2_i :
            (sr_sel(op) == 2'h2) ? stat3_i : stat1_i;
          SFCRA_C_ARRAY: shout <= rd_data_i;
          default: shout <= id_data_i;
        endcase
        if (rd_addr_o == `SFCRA_ADDR_TOP)
          rd_addr_o <= '0;
        else
          rd_addr_o <= rd_addr_o + 1'b1;
      end else begin
        shout <= {shout[6:0], 1'b0};
      end
    end
  end
  assign so_o = shout[7];

  AST_DESEL_HIZ: assert property (@(posedge core_clk_i)
    disable iff (rst_i) cs_n |=> !so_oe_o)
    else $error("output driven while deselected");
  AST_UNKNOWN_IGN: assert property (@(posedge core_clk_i)
    disable iff (rst_i) (phase == SFCRA_IGN && !cs_n) |=>
    (phase == SFCRA_IGN || cs_n)) else $error("left ignore");
  AST_WRAP: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (fall && phase == SFCRA_DAT && rd_cls && !cs_n && bitn == 3'h0 &&
     rd_addr_o == `SFCRA_ADDR_TOP) |=> rd_addr_o == '0)
    else $error("no wrap");
  AST_INCR: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (fall && phase == SFCRA_DAT && rd_cls && !cs_n && bitn == 3'h0 &&
     rd_addr_o != `SFCRA_ADDR_TOP) |=> rd_addr_o == $past(rd_addr_o) + 1'b1)
    else $error("no increment");
  AST_OPC_LEN: assert property (@(posedge core_clk_i) disable iff (rst_i)
    phase == SFCRA_OPC |-> cnt < `SFCRA_OP_BITS)
    else $error("opcode too long");
  AST_ADR_LEN: assert property (@(posedge core_clk_i) disable iff (rst_i)
    phase == SFCRA_ADR |-> cnt < `SFCRA_ADDR_BITS)
    else $error("address too long");
  AST_DUM_LEN: assert property (@(posedge core_clk_i) disable iff (rst_i)
    phase == SFCRA_DUM |-> cnt < `SFCRA_DUMMY_UID)
    else $error("dummy too long");
  AST_DESEL_IDLE: assert property (@(posedge core_clk_i)
    disable iff (rst_i) cs_n |=> phase == SFCRA_IDLE)
    else $error("no idle");
endmodule

//--- tb/sfcra_host.sv
// Purpose: SPI host model for the flash front end
// Assumes: mode 0; clock low outside frames
// Notes: link clock period 125 ns
`timescale 1ns/10ps
module sfcra_host (
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  // Offset keeps pin edges off core clock edges
  task sel();
    #0.25 cs_n_o = 1'b0;
    #62.5;
  endtask
  // MSB first both ways; SI changes on the fall
  task xfer(input logic [7:0] tx, input int n,
            output logic [7:0] rx, output logic oe);
    rx = 8'h00;
    oe = 1'b1;
    for (int i = 7; i > 7 - n; i--) begin
      si_o = tx[i];
      #62.5 sck_o = 1'b1;
      rx[i] = so_i;
      oe &= so_oe_i;
      #62.5 sck_o = 1'b0;
    end
  endtask
  // Released SI shows the inverse of its last value
  task desel();
    #62.5 cs_n_o = 1'b1;
    si_o = ~si_o;
    #300;
  endtask
endmodule

//--- tb/tb_sfcra_front.sv
// Purpose: self-checking bench for the flash front end
// Assumes: host model drives pins; array byte from address
// Notes: single-line mode 0 traffic only
`timescale 1ns/10ps
module tb_sfcra_front;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_n, sck, si, so, so_oe, st_wr, cmd, wr, oe;
  logic [18:0] rd_addr;
  logic [7:0] st_data, cmd_op, wr_data, rx;
  logic [1:0] st_sel;
  logic [23:0] cmd_addr;
  int miscompares = 0;
  int checks_done = 0;
  int n_cmd = 0;
  int n_st = 0;
  int n_wr = 0;
  always #4 core_clk_i = ~core_clk_i;
  // Array byte depends on every address bit
  function automatic logic [7:0] mem(input logic [18:0] a);
    return a[7:0] ^ a[18:11] ^ {5'h00, a[10:8]};
  endfunction
  sfcra_host i_host (.cs_n_o(cs_n), .sck_o(sck), .si_o(si),
    .so_i(so), .so_oe_i(so_oe));
  sfcra_front i_dut (.core_clk_i, .rst_i, .cs_n_i(cs_n),
    .sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(so_oe),
    .rd_addr_o(rd_addr), .rd_data_i(mem(rd_addr)),
    .stat1_i(8'h11), .stat2_i(8'h22), .stat3_i(8'h33),
    .id_data_i(8'hC3), .st_wr_sel_o(st_sel),
    .st_wr_data_o(st_data), .st_wr_o(st_wr), .cmd_op_o(cmd_op),
    .cmd_addr_o(cmd_addr), .cmd_o(cmd), .wr_data_o(wr_data),
    .wr_o(wr));
  // Pulses last one cycle, so count them here
  always @(posedge core_clk_i) begin
    if (cmd === 1'b1) n_cmd++;
    if (st_wr === 1'b1) n_st++;
    if (wr === 1'b1) n_wr++;
  end
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  // Select, opcode, optional three address bytes
  task hdr(input logic [7:0] op, input logic [23:0] a, input bit ad);
    @(negedge core_clk_i);
    i_host.sel();
    i_host.xfer(op, 8, rx, oe);
    for (int i = 2; i >= 0; i--)
      if (ad) i_host.xfer(a[i*8 +: 8], 8, rx, oe);
  endtask
  // Both reads; first one crosses the top of the array
  task t_read();
    logic [23:0] a [2];
    a = '{24'h87FFFE, 24'h012345};
    for (int j = 0; j < 2; j++) begin
      hdr(j ? 8'h0B : 8'h03, a[j], 1'b1);
      if (j) i_host.xfer(8'h00, 8, rx, oe);
      for (int k = 0; k < 4; k++) begin
        i_host.xfer(8'h00, 8, rx, oe);
        chk("read", mem(19'(a[j][18:0] + k)), rx);
        chk("so_oe", 1'b1, oe);
      end
      i_host.xfer(8'h00, 3, rx, oe);
      i_host.desel();
      chk("so_oe idle", 1'b0, so_oe);
    end
    $display("test read done");
  endtask
  // Each status register read, then written
  task t_stat();
    logic [7:0] rop [3];
    logic [7:0] wop [3];
    int c;
    rop = '{8'h05, 8'h35, 8'h15};
    wop = '{8'h01, 8'h31, 8'h11};
    for (int i = 0; i < 3; i++) begin
      hdr(rop[i], 24'h000000, 1'b0);
      i_host.xfer(8'h00, 8, rx, oe);
      i_host.desel();
      chk("status", 8'h11 * (i + 1), rx);
      c = n_st;
      hdr(wop[i], 24'h000000, 1'b0);
      i_host.xfer(8'h90 + i, 8, rx, oe);
      i_host.desel();
      chk("st_wr count", c + 1, n_st);
      chk("st_wr_sel", i, st_sel);
      chk("st_wr_data", 8'h90 + i, st_data);
    end
    $display("test status done");
  endtask
  // Identifier and parameter reads after their dummy clocks
  task t_info();
    logic [7:0] op [4];
    int dum [4];
    op = '{8'h4B, 8'h5A, 8'h48, 8'h9F};
    dum = '{4, 1, 1, 0};
    for (int i = 0; i < 4; i++) begin
      hdr(op[i], 24'h000010, i inside {1, 2});
      repeat (dum[i]) i_host.xfer(8'h00, 8, rx, oe);
      i_host.xfer(8'h00, 8, rx, oe);
      i_host.desel();
      chk("id byte", 8'hC3, rx);
    end
    $display("test info done");
  endtask
  // Erase, program and suspend report at deselect
  task t_cmd();
    logic [7:0] op [10];
    int c;
    int w;
    op = '{8'h20, 8'h52, 8'hD8, 8'h44, 8'h02, 8'h42,
           8'hC7, 8'h60, 8'h75, 8'h7A};
    w = n_wr;
    for (int i = 0; i < 10; i++) begin
      c = n_cmd;
      hdr(op[i], 24'h0A5A5A + i, i < 6);
      if (i inside {4, 5}) i_host.xfer(8'h96, 8, rx, oe);
      i_host.desel();
      chk("cmd count", c + 1, n_cmd);
      chk("cmd_op", op[i], cmd_op);
      if (i < 6) chk("cmd_addr", 24'h0A5A5A + i, cmd_addr);
    end
    chk("wr count", w + 2, n_wr);
    chk("wr_data", 8'h96, wr_data);
    $display("test commands done");
  endtask
  // Unknown opcode with a read pattern, then an erase deselected mid-address
  task t_bad();
    int c;
    c = n_cmd;
    hdr(8'hFF, 24'h030000, 1'b1);
    repeat (2) i_host.xfer(8'h00, 8, rx, oe);
    chk("so_oe ignored", 1'b0, oe);
    i_host.desel();
    hdr(8'h20, 24'h000000, 1'b0);
    i_host.xfer(8'h12, 8, rx, oe);
    i_host.xfer(8'h34, 8, rx, oe);
    i_host.desel();
    chk("cmd count", c, n_cmd);
    $display("test refuse done");
  endtask
  task results();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk_i);
    @(negedge core_clk_i) rst_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    t_read();
    t_stat();
    t_info();
    t_bad();
    t_cmd();
    results();
  end
endmodule
